// File: include/sbme_pkg.sv
// Package for the serial boot mode entry block: preset values, field positions, counts.
// Assumes a single 40 MHz CPU clock domain.
package sbme_pkg;
  // ****************************************
  // Preset configuration values
  // ****************************************
  localparam logic [15:0] SBME_CP_VAL = 16'hFA00;
  localparam logic [15:0] SBME_STACK_UNDERFLOW_LIMIT_VAL = 16'hFC00;
  localparam logic [15:0] SBME_SP_VAL = 16'hFA40;
  localparam logic [15:0] SBME_STACK_OVERFLOW_LIMIT_VAL = 16'hFA00;
  localparam logic [15:0] SBME_SYSCFG_VAL = 16'h0404;
  localparam logic [15:0] SBME_UCTL_VAL = 16'h8011;
  localparam logic [15:0] SBME_CANCTL_VAL = 16'h0000;
  localparam logic [15:0] SBME_PERIPH_VAL = 16'h042D;
  localparam logic [15:0] SBME_BUSCFG_OFF = 16'h0000;
  localparam logic [15:0] SBME_ZERO16 = 16'h0000;
  localparam logic [15:0] SBME_LOAD_BASE = 16'hFA40;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int SBME_INTERNAL_ROM_ENABLE_BIT = 10;
  localparam int SBME_BYTE_HIGH_DISABLE_BIT = 9;
  localparam int SBME_EXPANSION_PERIPH_ENABLE_BIT = 2;
  localparam int SBME_BUSACT_BIT = 10;
  localparam int SBME_ALE_BIT = 9;
  localparam int SBME_BUS_TYPE0_LO = 6;
  // ****************************************
  // Counts
  // ****************************************
  localparam int SBME_CAN_FILTER_CYC = 20;
  localparam int SBME_UART_BYTES = 32;
  localparam int SBME_CAN_BYTES = 128;
  localparam logic [7:0] SBME_UART_LAST = 8'h1F;
  localparam logic [7:0] SBME_CAN_LAST = 8'h7F;
  localparam logic [4:0] SBME_FILT_LAST = 5'h13;

  typedef enum logic [5:0] {
    SBME_IDLE = 6'b00_0001,
    SBME_SCAN = 6'b00_0010,
    SBME_UART = 6'b00_0100,
    SBME_CAN = 6'b00_1000,
    SBME_LOAD = 6'b01_0000,
    SBME_RUN = 6'b10_0000
  } sbme_state_t;

  typedef struct packed {
    logic [15:0] context_pointer;
    logic [15:0] stack_underflow_limit;
    logic [15:0] stack_pointer;
    logic [15:0] stack_overflow_limit;
    logic [15:0] system_config_reg;
    logic [15:0] bus_config0_reg;
  } sbme_core_cfg_t;

  typedef struct packed {
    logic [1:0] bus_type0;
    logic narrow_bus;
    logic eight_segments;
  } sbme_strap_t;
endpackage

// File: rtl/sbme_sync.sv
// Two-flop synchroniser for an asynchronous pin level.
// Assumes CLK_IN domain, synchronous active-low reset.
module sbme_sync
  import sbme_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic d_in,
  output logic q_out
);
  logic stage1;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      stage1 <= RESET_LEVEL;
      q_out <= RESET_LEVEL;
    end else begin
      stage1 <= d_in;
      q_out <= stage1;
    end
  end
endmodule

// File: rtl/sbme_top.sv
// Serial boot mode entry: strap capture, channel choice, preset configuration, loader count.
// Assumes one 40 MHz clock, synchronous active-low reset, raw pins from outside.
// Functional notes
// [RULE_01] Boot mode entered when boot strap is low at end of hardware reset.
// [RULE_02] Strap levels captured at rising edge of the reset pin.
// [RULE_03] Boot mode entered whatever bus mode the straps select.
// [RULE_04] After initialisation, watch both UART and CAN receive lines.
// [RULE_05] UART start condition selects UART boot channel.
// [RULE_06] Valid CAN dominant bit selects CAN boot channel.
// [RULE_07] UART wins after CAN falling edge until a valid CAN rising edge.
// [RULE_08] CAN low pulses under 20 cycles are filtered out.
// [RULE_09] Core pointers preset to FA00, FC00, FA40, FA00.
// [RULE_10] Watchdog held disabled in boot mode.
// [RULE_11] System config preset 0404, EXPANSION_PERIPH_ENABLE added for CAN boot.
// [RULE_12] ROM enable forced set, byte-high disable follows bus width strap.
// [RULE_13] Bus config zero if EA high, else bus active and ALE lengthen.
// [RULE_14] UART boot: control 8011, baud from zero byte, TX high output.
// [RULE_15] CAN boot: status zero, timing from zero frame, periph 042D, TX high.
// [RULE_16] Transmit pin of chosen channel becomes output for the acknowledge.
// [RULE_17] User flash instruction fetch blocked in boot mode.
// [RULE_18] Boot code runs from test flash, then downloaded code executes.
// [RULE_19] 32 UART or 128 CAN bytes stored sequentially from FA40.
// [RULE_20] CAN boot needs four or fewer segment lines.
// [RULE_21] Other receive line ignored once a channel is chosen.
//
// The implementer's own choices: the one-hot state encoding and the strobed byte input port.
module sbme_top
  import sbme_pkg::*;
#(
  parameter int BAUD_W = 16
) (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic BOOT_SELECT_STRAP_IN,
  input wire logic EXTERNAL_ACCESS_PIN_IN,
  input wire logic [1:0] BUS_TYPE_STRAP_IN,
  input wire logic NARROW_BUS_STRAP_IN,
  input wire logic EIGHT_SEGMENTS_STRAP_IN,
  input wire logic UART0_RECEIVE_LINE_IN,
  input wire logic CAN1_RECEIVE_LINE_IN,
  input wire logic INIT_DONE_IN,
  input wire logic BYTE_VALID_IN,
  input wire logic [7:0] BYTE_DATA_IN,
  output logic SERIAL_BOOT_MODE_OUT,
  output logic WATCHDOG_DISABLE_OUT,
  output logic USER_FETCH_BLOCK_OUT,
  output logic TEST_FLASH_FETCH_OUT,
  output logic UART_SELECTED_OUT,
  output logic CAN_SELECTED_OUT,
  output sbme_core_cfg_t CORE_CFG_OUT,
  output logic [15:0] UART0_CONTROL_REG_OUT,
  output logic [BAUD_W-1:0] UART0_BAUD_REG_OUT,
  output logic [15:0] CAN1_CTRL_REG_OUT,
  output logic [BAUD_W-1:0] CAN1_TIMING_REG_OUT,
  output logic [15:0] PERIPH_ENABLE_REG_OUT,
  output logic UART0_TRANSMIT_LINE_OUT,
  output logic UART0_TX_DIR_OUT,
  output logic CAN1_TRANSMIT_LINE_OUT,
  output logic CAN1_TX_DIR_OUT,
  output logic RAM_WE_OUT,
  output logic [15:0] RAM_ADDR_OUT,
  output logic [7:0] RAM_DATA_OUT,
  output logic EXEC_START_OUT,
  output logic [15:0] EXEC_ADDR_OUT
);
  // ****************************************
  // Synchronisers and strap capture
  // ****************************************
  logic rx_uart;
  logic rx_can;
  logic strap_boot;
  logic strap_ea;
  logic rst_q;
  logic boot_mode;
  sbme_strap_t straps;
  sbme_state_t state;

  sbme_sync u_sync_uart (
    .clk_in(CLK_IN), .resetn_in(RESETN_IN), .d_in(UART0_RECEIVE_LINE_IN), .q_out(rx_uart));
  sbme_sync u_sync_can (
    .clk_in(CLK_IN), .resetn_in(RESETN_IN), .d_in(CAN1_RECEIVE_LINE_IN), .q_out(rx_can));
  sbme_sync u_sync_boot (
    .clk_in(CLK_IN), .resetn_in(1'b1), .d_in(BOOT_SELECT_STRAP_IN), .q_out(strap_boot));
  sbme_sync u_sync_ea (
    .clk_in(CLK_IN), .resetn_in(1'b1), .d_in(EXTERNAL_ACCESS_PIN_IN), .q_out(strap_ea));

  logic ea_high;
  always_ff @(posedge CLK_IN) begin
    rst_q <= RESETN_IN;
  end

  // Catch straps in first cycle after reset release
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      boot_mode <= 1'b0;
      ea_high <= 1'b1;
      straps <= '0;
    end else if (!rst_q) begin
      boot_mode <= !strap_boot; // RULE_01
      ea_high <= strap_ea; // RULE_02
      straps <= {BUS_TYPE_STRAP_IN, NARROW_BUS_STRAP_IN, EIGHT_SEGMENTS_STRAP_IN}; // RULE_02
    end
  end

  // ****************************************
  // CAN glitch filter and priority window
  // ****************************************
  logic [4:0] low_cnt;
  logic can_dominant;
  logic can_prev;
  logic uart_prev;
  logic uart_prio;
  logic can_valid_rise;

  // Low run on the synced CAN line; dominant after 20 low cycles
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      low_cnt <= '0;
      can_dominant <= 1'b0;
    end else if (rx_can) begin
      low_cnt <= '0;
      can_dominant <= 1'b0;
    end else if (low_cnt == SBME_FILT_LAST) begin
      can_dominant <= 1'b1; // RULE_08
    end else begin
      low_cnt <= low_cnt + 5'd1; // RULE_08
    end
  end

  assign can_valid_rise = can_dominant && rx_can;

  // UART priority window: opened by a CAN fall, closed by a valid rise
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      can_prev <= 1'b1;
      uart_prev <= 1'b1;
      uart_prio <= 1'b0;
    end else begin
      can_prev <= rx_can;
      uart_prev <= rx_uart;
      if (can_prev && !rx_can) begin
        uart_prio <= 1'b1; // RULE_07
      end else if (can_valid_rise) begin
        uart_prio <= 1'b0; // RULE_07
      end
    end
  end

  logic uart_start;
  assign uart_start = uart_prev && !rx_uart;

  // ****************************************
  // Boot sequencer
  // ****************************************
  sbme_state_t next_state;
  logic [7:0] byte_cnt;
  logic [BAUD_W-1:0] meas;
  logic is_can;

  always_comb begin
    next_state = state;
    case (state)
      SBME_IDLE: begin
        if (boot_mode && INIT_DONE_IN) next_state = SBME_SCAN; // RULE_03
      end
      SBME_SCAN: begin
        // CAN taken only at its valid rise, so UART wins while CAN is dominant
        if (uart_start) next_state = SBME_UART; // RULE_05
        else if (can_valid_rise && uart_prio && !straps.eight_segments) next_state = SBME_CAN; // RULE_06 RULE_20
      end
      SBME_UART: begin
        if (!uart_prev && rx_uart) next_state = SBME_LOAD;
      end
      SBME_CAN: next_state = SBME_LOAD;
      SBME_LOAD: begin
        if (BYTE_VALID_IN && byte_cnt == (is_can ? SBME_CAN_LAST : SBME_UART_LAST)) next_state = SBME_RUN;
      end
      SBME_RUN: next_state = SBME_RUN;
      default: next_state = SBME_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      state <= SBME_IDLE;
    end else begin
      state <= next_state; // RULE_04
    end
  end

  // Channel latched once, held until reset
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      is_can <= 1'b0;
      UART_SELECTED_OUT <= 1'b0;
      CAN_SELECTED_OUT <= 1'b0;
    end else if (state == SBME_SCAN && next_state == SBME_UART) begin
      UART_SELECTED_OUT <= 1'b1; // RULE_21
    end else if (state == SBME_SCAN && next_state == SBME_CAN) begin
      CAN_SELECTED_OUT <= 1'b1; // RULE_21
      is_can <= 1'b1;
    end
  end

  // Zero byte/frame low time; the UART detect cycle already counts as low
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      meas <= '0;
    end else if (state == SBME_SCAN && next_state == SBME_UART) begin
      meas <= {{(BAUD_W-1){1'b0}}, 1'b1};
    end else if (state == SBME_SCAN && next_state == SBME_CAN) begin
      meas <= meas;
    end else if (state == SBME_SCAN && rx_can) begin
      meas <= '0;
    end else if ((state == SBME_SCAN && !rx_can) || (state == SBME_UART && !rx_uart)) begin
      meas <= meas + 1'b1;
    end
  end

  // ****************************************
  // Preset configuration
  // ****************************************
  logic [15:0] sys_cfg;
  logic [15:0] bus_cfg;
  always_comb begin
    sys_cfg = SBME_SYSCFG_VAL; // RULE_11
    sys_cfg[SBME_INTERNAL_ROM_ENABLE_BIT] = 1'b1; // RULE_12
    sys_cfg[SBME_BYTE_HIGH_DISABLE_BIT] = straps.narrow_bus; // RULE_12
    bus_cfg = SBME_BUSCFG_OFF; // RULE_13
    if (!ea_high) begin
      bus_cfg[SBME_BUSACT_BIT] = 1'b1; // RULE_13
      bus_cfg[SBME_ALE_BIT] = 1'b1; // RULE_13
      bus_cfg[SBME_BUS_TYPE0_LO +: 2] = straps.bus_type0; // RULE_13
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      SERIAL_BOOT_MODE_OUT <= 1'b0;
      WATCHDOG_DISABLE_OUT <= 1'b0;
      USER_FETCH_BLOCK_OUT <= 1'b0;
      TEST_FLASH_FETCH_OUT <= 1'b0;
      CORE_CFG_OUT <= '0;
    end else begin
      SERIAL_BOOT_MODE_OUT <= boot_mode;
      WATCHDOG_DISABLE_OUT <= boot_mode; // RULE_10
      USER_FETCH_BLOCK_OUT <= boot_mode; // RULE_17
      TEST_FLASH_FETCH_OUT <= boot_mode && state != SBME_RUN; // RULE_18
      if (boot_mode) begin
        CORE_CFG_OUT.context_pointer <= SBME_CP_VAL; // RULE_09
        CORE_CFG_OUT.stack_underflow_limit <= SBME_STACK_UNDERFLOW_LIMIT_VAL; // RULE_09
        CORE_CFG_OUT.stack_pointer <= SBME_SP_VAL; // RULE_09
        CORE_CFG_OUT.stack_overflow_limit <= SBME_STACK_OVERFLOW_LIMIT_VAL; // RULE_09
        CORE_CFG_OUT.bus_config0_reg <= bus_cfg;
        CORE_CFG_OUT.system_config_reg <= sys_cfg | (16'(is_can) << SBME_EXPANSION_PERIPH_ENABLE_BIT); // RULE_11
      end
    end
  end

  // Channel peripheral presets
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      UART0_CONTROL_REG_OUT <= SBME_ZERO16;
      UART0_BAUD_REG_OUT <= '0;
      CAN1_CTRL_REG_OUT <= SBME_ZERO16;
      CAN1_TIMING_REG_OUT <= '0;
      PERIPH_ENABLE_REG_OUT <= SBME_ZERO16;
      UART0_TRANSMIT_LINE_OUT <= 1'b1;
      UART0_TX_DIR_OUT <= 1'b0;
      CAN1_TRANSMIT_LINE_OUT <= 1'b1;
      CAN1_TX_DIR_OUT <= 1'b0;
    end else begin
      if (state == SBME_UART && next_state == SBME_LOAD) begin
        UART0_CONTROL_REG_OUT <= SBME_UCTL_VAL; // RULE_14
        UART0_BAUD_REG_OUT <= meas; // RULE_14
        UART0_TRANSMIT_LINE_OUT <= 1'b1; // RULE_14
        UART0_TX_DIR_OUT <= 1'b1; // RULE_16
      end
      if (state == SBME_CAN && next_state == SBME_LOAD) begin
        CAN1_CTRL_REG_OUT <= SBME_CANCTL_VAL; // RULE_15
        CAN1_TIMING_REG_OUT <= meas; // RULE_15
        PERIPH_ENABLE_REG_OUT <= SBME_PERIPH_VAL; // RULE_15
        CAN1_TRANSMIT_LINE_OUT <= 1'b1; // RULE_15
        CAN1_TX_DIR_OUT <= 1'b1; // RULE_16
      end
    end
  end

  // ****************************************
  // Download into dual-port RAM
  // ****************************************
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      byte_cnt <= '0;
      RAM_WE_OUT <= 1'b0;
      RAM_ADDR_OUT <= SBME_LOAD_BASE;
      RAM_DATA_OUT <= '0;
      EXEC_START_OUT <= 1'b0;
      EXEC_ADDR_OUT <= SBME_LOAD_BASE;
    end else begin
      RAM_WE_OUT <= 1'b0;
      EXEC_START_OUT <= 1'b0;
      if (state == SBME_LOAD && BYTE_VALID_IN) begin
        RAM_WE_OUT <= 1'b1; // RULE_19
        RAM_ADDR_OUT <= SBME_LOAD_BASE + {8'h00, byte_cnt}; // RULE_19
        RAM_DATA_OUT <= BYTE_DATA_IN;
        byte_cnt <= byte_cnt + 8'd1;
      end
      if (state == SBME_LOAD && next_state == SBME_RUN) begin
        EXEC_START_OUT <= 1'b1; // RULE_18
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_wdt_boot: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    WATCHDOG_DISABLE_OUT == $past(boot_mode)) else $error("watchdog not held off"); // RULE_10
  a_fetch_block: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    SERIAL_BOOT_MODE_OUT |-> USER_FETCH_BLOCK_OUT) else $error("user fetch not blocked"); // RULE_17
  a_filter_short: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    $rose(can_dominant) |-> $past(!rx_can, 1) && low_cnt == SBME_FILT_LAST) else $error("short CAN pulse"); // RULE_08
  a_one_channel: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    !(UART_SELECTED_OUT && CAN_SELECTED_OUT)) else $error("both channels chosen"); // RULE_21
  a_chan_hold: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    $past(UART_SELECTED_OUT) |-> UART_SELECTED_OUT) else $error("channel dropped"); // RULE_21
  a_uart_preset: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    $rose(UART0_TX_DIR_OUT) |-> UART0_CONTROL_REG_OUT == SBME_UCTL_VAL && UART0_TRANSMIT_LINE_OUT)
    else $error("UART preset wrong"); // RULE_14
  a_can_preset: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    $rose(CAN1_TX_DIR_OUT) |-> PERIPH_ENABLE_REG_OUT == SBME_PERIPH_VAL && CAN_SELECTED_OUT)
    else $error("CAN preset wrong"); // RULE_15
  a_core_ptrs: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    $past(boot_mode, 2) && boot_mode |-> CORE_CFG_OUT.stack_pointer == SBME_SP_VAL
      && CORE_CFG_OUT.system_config_reg[SBME_INTERNAL_ROM_ENABLE_BIT]) else $error("core preset wrong"); // RULE_09
  a_ram_addr: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    RAM_WE_OUT |-> RAM_ADDR_OUT == SBME_LOAD_BASE + {8'h00, byte_cnt - 8'd1}) else $error("RAM address off"); // RULE_19
  a_can_segs: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    $rose(CAN_SELECTED_OUT) |-> !straps.eight_segments) else $error("CAN with eight segments"); // RULE_20
  a_can_on_rise: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RULE_07
    $rose(CAN_SELECTED_OUT) |-> $past(can_valid_rise)) else $error("CAN chosen before valid rise");
  a_exec_last: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RULE_18
    EXEC_START_OUT |-> RAM_WE_OUT) else $error("start without last byte");
  c_uart_boot: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN) $rose(UART_SELECTED_OUT));
  c_can_boot: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN) $rose(CAN_SELECTED_OUT));
  c_exec: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN) EXEC_START_OUT);
  c_uart_over_can: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN) $rose(UART_SELECTED_OUT) && can_dominant);
endmodule

// File: verif/sbme_host.sv
// Host model: drives the UART and CAN receive lines and the downloaded bytes.
// Assumes lines idle high through pull-ups; changes only just after a rising edge.
module sbme_host (
  input wire logic clk_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic uart_rx = 1'b1;
  logic can_rx = 1'b1;
  logic byte_valid = 1'b0;
  logic [7:0] byte_data = 8'h00;
  logic [7:0] sent_q[$];
  // Low pulse of n cycles on the UART line (start plus zero data bits)
  task automatic uart_zero(input int n);
    @(posedge clk_in);
    uart_rx <= 1'b0;
    repeat (n) @(posedge clk_in);
    uart_rx <= 1'b1;
  endtask
  // Dominant level of n cycles on the CAN line
  task automatic can_low(input int n);
    @(posedge clk_in);
    can_rx <= 1'b0;
    repeat (n) @(posedge clk_in);
    can_rx <= 1'b1;
  endtask
  // Download of n bytes, gaps of 0 to 2 cycles
  task automatic send_bytes(input int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      @(posedge clk_in);
      byte_valid <= 1'b1;
      byte_data <= b;
      sent_q.push_back(b);
      repeat ($urandom_range(0, 2)) begin
        @(posedge clk_in);
        byte_valid <= 1'b0;
        byte_data <= ~b;
      end
    end
    @(posedge clk_in);
    byte_valid <= 1'b0;
    byte_data <= ~b;
  endtask
endmodule

// File: verif/sbme_top_bench.sv
// Self-checking bench for the serial boot mode entry block.
// Assumes the host model drives the receive lines and the byte stream.
module sbme_top_bench
  import sbme_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic strap = 1'b1;
  logic ea = 1'b1;
  logic narrow = 1'b0;
  logic eight = 1'b0;
  logic init_done = 1'b0;
  logic [1:0] bus_type = 2'b00;
  logic boot, wd_dis, fetch_blk, tf_fetch, uart_sel, can_sel;
  sbme_core_cfg_t cfg;
  logic [15:0] uctl, ubaud, cctl, ctim, periph, ram_addr, exec_addr;
  logic utx, udir, ctx, cdir, ram_we, exec_start;
  logic [7:0] ram_data;
  int err_count = 0;
  int check_count = 0;
  int we_count = 0;
  int exec_count = 0;
  sbme_host host(.clk_in(clk_in));
  sbme_top dut(.CLK_IN(clk_in), .RESETN_IN(resetn_in), .BOOT_SELECT_STRAP_IN(strap),
    .EXTERNAL_ACCESS_PIN_IN(ea), .BUS_TYPE_STRAP_IN(bus_type), .NARROW_BUS_STRAP_IN(narrow),
    .EIGHT_SEGMENTS_STRAP_IN(eight), .UART0_RECEIVE_LINE_IN(host.uart_rx),
    .CAN1_RECEIVE_LINE_IN(host.can_rx), .INIT_DONE_IN(init_done), .BYTE_VALID_IN(host.byte_valid),
    .BYTE_DATA_IN(host.byte_data), .SERIAL_BOOT_MODE_OUT(boot), .WATCHDOG_DISABLE_OUT(wd_dis),
    .USER_FETCH_BLOCK_OUT(fetch_blk), .TEST_FLASH_FETCH_OUT(tf_fetch), .UART_SELECTED_OUT(uart_sel),
    .CAN_SELECTED_OUT(can_sel), .CORE_CFG_OUT(cfg), .UART0_CONTROL_REG_OUT(uctl),
    .UART0_BAUD_REG_OUT(ubaud), .CAN1_CTRL_REG_OUT(cctl), .CAN1_TIMING_REG_OUT(ctim),
    .PERIPH_ENABLE_REG_OUT(periph), .UART0_TRANSMIT_LINE_OUT(utx), .UART0_TX_DIR_OUT(udir),
    .CAN1_TRANSMIT_LINE_OUT(ctx), .CAN1_TX_DIR_OUT(cdir), .RAM_WE_OUT(ram_we),
    .RAM_ADDR_OUT(ram_addr), .RAM_DATA_OUT(ram_data), .EXEC_START_OUT(exec_start),
    .EXEC_ADDR_OUT(exec_addr));
  always #12.5 clk_in = ~clk_in;
  // ****************************************
  // Compare, verdict, expectations
  // ****************************************
  task automatic chk1(input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk16(input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [15:0] exp_sys(input logic can_boot, input logic nb);
    logic [15:0] v;
    v = SBME_SYSCFG_VAL;
    v[SBME_INTERNAL_ROM_ENABLE_BIT] = 1'b1;
    v[SBME_BYTE_HIGH_DISABLE_BIT] = nb;
    v[SBME_EXPANSION_PERIPH_ENABLE_BIT] = v[SBME_EXPANSION_PERIPH_ENABLE_BIT] | can_boot;
    return v;
  endfunction
  function automatic logic [15:0] exp_bus(input logic e, input logic [1:0] bt);
    logic [15:0] v;
    v = SBME_BUSCFG_OFF;
    v[SBME_BUSACT_BIT] = ~e;
    v[SBME_ALE_BIT] = ~e;
    v[SBME_BUS_TYPE0_LO+:2] = e ? 2'b00 : bt;
    return v;
  endfunction
  // ****************************************
  // Load monitor and scenario tasks
  // ****************************************
  always @(negedge clk_in) begin
    if (resetn_in && ram_we === 1'b1) begin
      chk16(SBME_LOAD_BASE + 16'(we_count), ram_addr);
      chk16({8'h00, host.sent_q[we_count]}, {8'h00, ram_data});
      we_count++;
    end
    if (resetn_in && exec_start === 1'b1) begin
      exec_count++;
      chk16(SBME_LOAD_BASE, exec_addr);
    end
  end
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic boot_up(input logic s, input logic e, input logic es);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    init_done <= 1'b0;
    strap <= s;
    ea <= e;
    eight <= es;
    narrow <= 1'($urandom);
    bus_type <= 2'($urandom);
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    settle(4);
    we_count = 0;
    exec_count = 0;
    host.sent_q.delete();
    chk1(~s, boot);
    chk1(~s, wd_dis);
    chk1(~s, fetch_blk);
    chk1(~s, tf_fetch);
    @(posedge clk_in);
    init_done <= 1'b1;
  endtask
  task automatic can_frame;
    host.can_low(10);
    settle(3);
    chk1(1'b0, can_sel);
    host.can_low(30);
    repeat (4) @(posedge clk_in);
    host.can_low(30);
    settle(5);
  endtask
  task automatic chk_core(input logic can_boot);
    chk16(SBME_CP_VAL, cfg.context_pointer);
    chk16(SBME_STACK_UNDERFLOW_LIMIT_VAL, cfg.stack_underflow_limit);
    chk16(SBME_SP_VAL, cfg.stack_pointer);
    chk16(SBME_STACK_OVERFLOW_LIMIT_VAL, cfg.stack_overflow_limit);
    chk16(exp_sys(can_boot, narrow), cfg.system_config_reg);
    chk16(exp_bus(ea, bus_type), cfg.bus_config0_reg);
  endtask
  task automatic load(input int n);
    host.send_bytes(n);
    settle(4);
    chk16(16'(n), 16'(we_count));
    chk16(16'h0001, 16'(exec_count));
    chk1(1'b0, tf_fetch);
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    #(25ns * 30000);
    err_count++;
    close_out();
  end
  initial begin
    int n;
    void'($urandom(7));
    boot_up(1'b1, 1'b1, 1'b0);
    host.uart_zero(10);
    settle(5);
    chk1(1'b0, uart_sel);
    chk16(SBME_ZERO16, cfg.stack_pointer);
    boot_up(1'b0, 1'b1, 1'b0);
    n = $urandom_range(12, 60);
    host.uart_zero(n);
    settle(5);
    chk1(1'b1, uart_sel);
    chk16(SBME_UCTL_VAL, uctl);
    chk16(16'(n), ubaud);
    chk1(1'b1, utx);
    chk1(1'b1, udir);
    chk1(1'b0, cdir);
    chk16(SBME_ZERO16, periph);
    chk_core(1'b0);
    host.can_low(40);
    settle(5);
    chk1(1'b0, can_sel);
    load(SBME_UART_BYTES);
    strap <= 1'b1;
    settle(4);
    chk1(1'b1, boot);
    boot_up(1'b0, 1'b0, 1'b0);
    fork
      host.can_low(40);
      begin
        repeat (25) @(posedge clk_in);
        host.uart_zero(10);
      end
    join
    settle(5);
    chk1(1'b1, uart_sel);
    chk1(1'b0, can_sel);
    boot_up(1'b0, 1'b0, 1'b0);
    can_frame();
    chk1(1'b1, can_sel);
    chk16(SBME_CANCTL_VAL, cctl);
    chk16(16'd30, ctim);
    chk16(SBME_PERIPH_VAL, periph);
    chk1(1'b1, ctx);
    chk1(1'b1, cdir);
    chk1(1'b0, udir);
    chk_core(1'b1);
    host.uart_zero(10);
    settle(5);
    chk1(1'b0, uart_sel);
    load(SBME_CAN_BYTES);
    boot_up(1'b0, 1'b0, 1'b1);
    can_frame();
    chk1(1'b0, can_sel);
    close_out();
  end
endmodule
